// ---- testbench/esc_stats_tb_top.sv ----
// self-checking bench for the statistics counter bank
// assumes esc_pkg compiled first and a 100 MHz stats clock
`timescale 1ns/100ps
`include "esc_map.svh"
module esc_stats_tb_top
    import esc_pkg::*;
();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`ESC_LAST_LF:`ESC_FIRST_LF] inc_vec;
    logic [`ESC_LAST_LF:`ESC_FIRST_LF] tog_req = '0;
    logic [`ESC_NUM_HF-1:0] hf_inc = '0;
    esc_req_t req = '0;
    esc_rsp_t rsp;
    int err_total = 0;
    int total_checks = 0;
    // 100 MHz is above the 10/100 line rate clock
    initial forever #5 clk = ~clk;
    esc_stats #(.CNT_W(64), .MGMT_EN(1'b1), .RST_CLEARS(1'b1)) i_dut (
        .CLK_I(clk), .RESETN_I(rst_n), .INC_VEC_I(inc_vec),
        .HF_INC_I(hf_inc), .REQ_I(req), .RSP_O(rsp));
    esc_vec_src i_src (.clk_i(clk), .tog_req_i(tog_req), .vec_o(inc_vec));
    ////////////////////////////////////////////////////////////////////
    // shared compare, verdict and bus tasks
    task automatic chk(input string what, input logic [63:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one access; a gap cycle first so the request never re-drives at once
    task automatic acc(input logic wr, input int idx, input logic up,
                       output esc_rsp_t r);
        int n;
        @(posedge clk);
        #1 req = {1'b1, wr, idx[5:0], up};
        @(posedge clk);
        #1 req = '0;
        for (n = 0; n < 4 && rsp.ack !== 1'b1; n++)
            @(posedge clk) #1;
        if (rsp.ack !== 1'b1) begin
            err_total++;
            $display("unexpected no answer for index %0d", idx);
            results();
        end
        r = rsp;
    endtask
    task automatic rd(input int idx, input logic up, input logic err,
                      input logic [31:0] exp, input string what);
        esc_rsp_t r;
        acc(1'b0, idx, up, r);
        chk({what, " err"}, r.err, err);
        chk(what, r.data, exp);
    endtask
    // flip one bus bit, then wait out the frame gap and one full pass
    task automatic bump(input int b);
        @(posedge clk);
        #1 tog_req[b] = 1'b1;
        @(posedge clk);
        #1 tog_req = '0;
        repeat (`ESC_MIN_FRAME_CYC + 72) @(posedge clk);
    endtask
    task automatic do_reset();
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (70) @(posedge clk); // memory clear walk needs 45 edges
        #1 rst_n = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_clear();
        rd(5, 1'b0, 1'b0, 32'h0000_0000, "low after reset");
        rd(5, 1'b1, 1'b0, 32'h0000_0000, "high after reset");
        $display("test clear done");
    endtask
    task automatic t_toggle();
        int bits[4] = '{4, 11, 19, 43};
        foreach (bits[i]) begin
            bump(bits[i]);
            bump(bits[i]);
            rd(bits[i], 1'b0, 1'b0, 32'h0000_0002, "bus count");
            rd(bits[i], 1'b0, 1'b0, 32'h0000_0002, "reread");
            rd(bits[i], 1'b1, 1'b0, 32'h0000_0000, "held high");
        end
        $display("test toggle done");
    endtask
    task automatic t_size();
        bump(12);
        bump(30);
        rd(12, 1'b0, 1'b0, 32'h0000_0001, "rx size");
        rd(30, 1'b0, 1'b0, 32'h0000_0001, "tx size");
        rd(13, 1'b0, 1'b0, 32'h0000_0000, "idle size");
        $display("test size done");
    endtask
    task automatic t_fast();
        for (int n = 0; n < `ESC_NUM_HF; n++) begin
            @(posedge clk);
            #1 hf_inc[n] = 1'b1;
            repeat (n + 3) @(posedge clk);
            #1 hf_inc = '0;
        end
        repeat (80) @(posedge clk);
        for (int n = 0; n < `ESC_NUM_HF; n++)
            rd(n, 1'b0, 1'b0, 32'(n + 3), "fast count");
        $display("test fast done");
    endtask
    task automatic t_access();
        esc_rsp_t r;
        rd(4, 1'b0, 1'b0, 32'h0000_0002, "low of 4");
        rd(5, 1'b1, 1'b1, 32'h0000_0000, "other high");
        rd(4, 1'b1, 1'b0, 32'h0000_0000, "own high");
        rd(44, 1'b0, 1'b1, 32'h0000_0000, "past top");
        acc(1'b1, 4, 1'b0, r);
        chk("write err", r.err, 1'b1);
        rd(4, 1'b0, 1'b0, 32'h0000_0002, "after write");
        $display("test access done");
    endtask
    task automatic t_rereset();
        do_reset();
        rd(4, 1'b1, 1'b1, 32'h0000_0000, "high no low");
        rd(4, 1'b0, 1'b0, 32'h0000_0000, "cleared");
        rd(0, 1'b0, 1'b0, 32'h0000_0000, "fast cleared");
        $display("test rereset done");
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        do_reset();
        t_clear();
        t_toggle();
        t_size();
        t_fast();
        t_access();
        t_rereset();
        results();
    end
endmodule // esc_stats_tb_top

// ---- testbench/esc_vec_src.sv ----
// partner model: vector decode logic driving the toggle increment bus
// assumes one stats clock; bench pulses tog_req_i for one cycle per bump
`timescale 1ns/100ps
`include "esc_map.svh"
module esc_vec_src (
    input wire logic clk_i, // stats reference clock
    input wire logic [`ESC_LAST_LF:`ESC_FIRST_LF] tog_req_i, // bits to bump
    output logic [`ESC_LAST_LF:`ESC_FIRST_LF] vec_o // toggle bus
);
    int gap = 0;
    logic [`ESC_LAST_LF:`ESC_FIRST_LF] lvl = '0;
    assign vec_o = lvl;
    ////////////////////////////////////////////////////////////////////
    // a bump is a level flip; requests inside the frame gap are dropped
    // so the model never outruns a real minimum-size frame source
    always @(posedge clk_i) begin
        if (gap > 0)
            gap <= gap - 1;
        if (tog_req_i != '0 && gap == 0) begin
            lvl <= lvl ^ tog_req_i;
            gap <= `ESC_MIN_FRAME_CYC;
        end
    end
endmodule // esc_vec_src

// ---- verilog/esc_map.svh ----
// offsets, widths and timing counts for the statistics counter bank
// assumes inclusion by bare name from the package and the design module
`ifndef ESC_MAP_SVH
`define ESC_MAP_SVH
`define ESC_NUM_CNT 44
`define ESC_FIRST_LF 4
`define ESC_LAST_LF 43
`define ESC_NUM_HF 4
`define ESC_CNT_W_DEF 64
`define ESC_HALF_W 32
`define ESC_ADDR_W 7
`define ESC_IDX_W 6
// frame-size groups: rx 7 counters, tx 7 counters, one-hot per frame
`define ESC_RX_SIZE_LO 6'h0C
`define ESC_TX_SIZE_LO 6'h1B
`define ESC_SIZE_N 7
// shortest allowed toggle spacing on the increment bus
`define ESC_MIN_FRAME_NS 584
`define ESC_CLK_NS 10
`define ESC_MIN_FRAME_CYC ((`ESC_MIN_FRAME_NS) / (`ESC_CLK_NS))
`endif

// ---- verilog/esc_pkg.sv ----
// types for the statistics counter bank
// assumes esc_map.svh on the include path
`include "esc_map.svh"
package esc_pkg;
    typedef enum logic [2:0] {
        ESC_IDLE = 3'b001,
        ESC_READ = 3'b010,
        ESC_WRITE = 3'b100
    } esc_state_t;
    typedef struct packed {
        logic req;
        logic wr;
        logic [`ESC_ADDR_W-1:0] addr;
    } esc_req_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [`ESC_HALF_W-1:0] data;
    } esc_rsp_t;
endpackage

// ---- verilog/esc_stats.sv ----
// statistics counter bank: toggle-fed counters in a memory, round robin
// assumes one clock (stats reference clock), synchronous active-low reset
`timescale 1ns/100ps
`include "esc_map.svh"
module esc_stats
    import esc_pkg::*;
#(
    parameter int CNT_W = `ESC_CNT_W_DEF,     // 32 or 64
    parameter bit MGMT_EN = 1'b1,             // management interface present
    parameter bit RST_CLEARS = 1'b1           // clear counters on reset
) (
    input wire logic CLK_I,                   // stats reference clock
    input wire logic RESETN_I,                // sync reset, active low
    input wire logic [`ESC_LAST_LF:`ESC_FIRST_LF] INC_VEC_I, // toggle bus
    input wire logic [`ESC_NUM_HF-1:0] HF_INC_I, // fast per-cycle incs
    input wire esc_req_t REQ_I,               // management access
    output esc_rsp_t RSP_O                    // management answer
);

////////////////////////////////////////////////////////////////////////
// high-frequency counters 0-3, plain registers since they may step
// every cycle and the shared memory could not keep pace
logic [CNT_W-1:0] hf_cnt [`ESC_NUM_HF];
logic hf_clear;
assign hf_clear = !RESETN_I && RST_CLEARS;

genvar g;
generate
    for (g = 0; g < `ESC_NUM_HF; g++) begin : g_hf
        always_ff @(posedge CLK_I) begin
            if (hf_clear) begin
                hf_cnt[g] <= '0;
            end else if (HF_INC_I[g]) begin
                hf_cnt[g] <= hf_cnt[g] + 1'b1;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// toggle detection and pending flags for counters 4..43
logic [`ESC_LAST_LF:`ESC_FIRST_LF] inc_q;
logic [`ESC_LAST_LF:`ESC_FIRST_LF] toggle;
logic [`ESC_LAST_LF:`ESC_FIRST_LF] pend;
logic [`ESC_LAST_LF:`ESC_FIRST_LF] svc_clr;
assign toggle = (INC_VEC_I ^ inc_q) & {(`ESC_NUM_CNT-4){RESETN_I}};

// inc_q samples the bus each clock; first cycle after reset sees no toggle
always_ff @(posedge CLK_I) begin
    inc_q <= INC_VEC_I;
end

// set wins over service clear so a toggle in the service cycle survives
always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
        pend <= '0;
    end else begin
        pend <= (pend & ~svc_clr) | toggle;
    end
end

////////////////////////////////////////////////////////////////////////
// round-robin sequencer; frame-size groups collapse to one slot each
logic [`ESC_IDX_W-1:0] slot;
logic [`ESC_IDX_W-1:0] next_slot;
logic [`ESC_IDX_W-1:0] visit;
logic [`ESC_IDX_W-1:0] rx_pick;
logic [`ESC_IDX_W-1:0] tx_pick;
esc_state_t state;
esc_state_t next_state;

// lowest pending counter in each one-hot frame-size group
always_comb begin
    rx_pick = `ESC_RX_SIZE_LO;
    tx_pick = `ESC_TX_SIZE_LO;
    for (int i = `ESC_SIZE_N - 1; i >= 0; i--) begin
        if (pend[`ESC_RX_SIZE_LO + i]) begin
            rx_pick = `ESC_RX_SIZE_LO + 6'(i);
        end
        if (pend[`ESC_TX_SIZE_LO + i]) begin
            tx_pick = `ESC_TX_SIZE_LO + 6'(i);
        end
    end
end

// slot jumps past the other six of a group: 40 counters in 28 visits
assign visit = (slot == `ESC_RX_SIZE_LO) ? rx_pick :
               (slot == `ESC_TX_SIZE_LO) ? tx_pick : slot;
assign next_slot = (slot == `ESC_LAST_LF) ? 6'(`ESC_FIRST_LF) :
    (slot == `ESC_RX_SIZE_LO) ? `ESC_RX_SIZE_LO + 6'(`ESC_SIZE_N) :
    (slot == `ESC_TX_SIZE_LO) ? `ESC_TX_SIZE_LO + 6'(`ESC_SIZE_N) :
    slot + 6'h01;

// two accesses per visit: read, then write-back
always_comb begin
    unique case (state)
        ESC_IDLE: next_state = ESC_READ;
        ESC_READ: next_state = ESC_WRITE;
        ESC_WRITE: next_state = ESC_READ;
        default: next_state = ESC_IDLE;
    endcase
end

always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
        state <= ESC_IDLE;
        slot <= 6'(`ESC_FIRST_LF);
    end else begin
        state <= next_state;
        if (state == ESC_WRITE) begin
            slot <= next_slot;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// counter memory; a reset clear walks its own index, so a clearing reset
// must be held for 45 edges to zero every entry
logic [CNT_W-1:0] mem [`ESC_NUM_CNT];
logic [CNT_W-1:0] rd_val;
logic [`ESC_IDX_W-1:0] vis_q;
logic vis_pend;
logic [CNT_W-1:0] wr_val;
logic mem_clear;
logic clr_walk;
assign mem_clear = !RESETN_I && RST_CLEARS;
assign vis_pend = pend[vis_q];
assign wr_val = vis_pend ? rd_val + 1'b1 : rd_val;

// reset clear sweeps the whole memory quickly via a separate index;
// the first clearing edge only parks the index at zero, since the
// index has no power-up value and would otherwise sweep nowhere
logic [`ESC_IDX_W-1:0] clr_idx;
logic clr_run;
assign clr_walk = mem_clear;

always_ff @(posedge CLK_I) begin
    clr_run <= clr_walk;
    if (clr_walk && clr_run) begin
        clr_idx <= (clr_idx == 6'(`ESC_NUM_CNT - 1)) ? 6'h00 :
            clr_idx + 6'h01;
    end else begin
        clr_idx <= 6'h00;
    end
end

// read access latches value and index
always_ff @(posedge CLK_I) begin
    if (state == ESC_READ) begin
        rd_val <= mem[visit];
        vis_q <= visit;
    end
end

// write-back access, or reset clear when enabled
always_ff @(posedge CLK_I) begin
    if (clr_walk) begin
        mem[clr_idx] <= '0;
    end else if (state == ESC_WRITE) begin
        mem[vis_q] <= wr_val;
    end
end

always_comb begin
    svc_clr = '0;
    if (state == ESC_WRITE && vis_pend) begin
        svc_clr[vis_q] = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// management read port: addr[0] selects upper half, addr[6:1] counter
logic [`ESC_IDX_W-1:0] acc_idx;
logic acc_upper;
logic [CNT_W-1:0] acc_val;
logic [`ESC_HALF_W-1:0] hold;
logic [`ESC_IDX_W-1:0] hold_idx;
logic hold_ok;
logic bad_addr;
logic rd_lower;
logic rd_upper;
logic up_err;
esc_rsp_t next_rsp;

assign acc_idx = REQ_I.addr[`ESC_ADDR_W-1:1];
assign acc_upper = REQ_I.addr[0];
assign bad_addr = (acc_idx >= 6'(`ESC_NUM_CNT)) || !MGMT_EN;
assign acc_val = bad_addr ? '0 :
    (acc_idx < 6'(`ESC_NUM_HF)) ? hf_cnt[acc_idx[1:0]] : mem[acc_idx];
assign rd_lower = REQ_I.req && !REQ_I.wr && !acc_upper && !bad_addr;
assign rd_upper = REQ_I.req && !REQ_I.wr && acc_upper && !bad_addr;
assign up_err = rd_upper &&
    (CNT_W == `ESC_HALF_W || !hold_ok || hold_idx != acc_idx);

// answer mux: writes and stray addresses end in error
always_comb begin
    next_rsp.ack = REQ_I.req;
    next_rsp.err = REQ_I.req && (REQ_I.wr || bad_addr || up_err);
    next_rsp.data = '0;
    if (rd_lower) begin
        next_rsp.data = acc_val[`ESC_HALF_W-1:0];
    end else if (rd_upper && !up_err) begin
        next_rsp.data = hold;
    end
end

// lower read captures the upper half alongside
always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
        hold <= '0;
        hold_idx <= '0;
        hold_ok <= 1'b0;
    end else if (rd_lower) begin
        hold <= (CNT_W > `ESC_HALF_W) ?
            `ESC_HALF_W'(acc_val >> `ESC_HALF_W) : '0;
        hold_idx <= acc_idx;
        hold_ok <= 1'b1;
    end
end

always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
        RSP_O <= '0;
    end else begin
        RSP_O <= next_rsp;
    end
end

////////////////////////////////////////////////////////////////////////
// checks
upper_err_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    rd_upper && hold_ok && hold_idx != acc_idx |=> RSP_O.err)
    else $error("upper read of other counter without error");
write_err_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    REQ_I.req && REQ_I.wr |=> RSP_O.ack && RSP_O.err)
    else $error("write not answered with error");
upper_hold_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    rd_upper && hold_ok && hold_idx == acc_idx && CNT_W > 32
    |=> !RSP_O.err && RSP_O.data == $past(hold))
    else $error("upper read did not return held value");
lower_cap_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    rd_lower && CNT_W > 32
    |=> hold == `ESC_HALF_W'($past(acc_val) >> `ESC_HALF_W))
    else $error("upper half not captured");
// every toggled bit must show up as pending, not just one sample bit
toggle_pend_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    toggle != '0 |=> (pend & $past(toggle)) == $past(toggle))
    else $error("toggle lost");
seq_rw_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    state == ESC_READ |=> state == ESC_WRITE ##1 state == ESC_READ)
    else $error("read/write alternation broken");
svc_clear_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    state == ESC_WRITE && vis_pend && !toggle[vis_q]
    |=> !pend[$past(vis_q)])
    else $error("serviced pend not cleared");
slot_skip_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    state == ESC_WRITE && slot == `ESC_RX_SIZE_LO
    |=> slot == `ESC_RX_SIZE_LO + `ESC_SIZE_N)
    else $error("frame-size group not skipped");
// judged on the stored word, so a broken write-back path is caught too
inc_wb_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    state == ESC_WRITE && vis_pend
    |=> mem[$past(vis_q)] == $past(rd_val) + 1'b1)
    else $error("pending visit did not increment");
hf_step_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    HF_INC_I[0] |=> hf_cnt[0] == $past(hf_cnt[0]) + 1'b1)
    else $error("fast counter missed a step");
hf_hold_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    !HF_INC_I[0] |=> hf_cnt[0] == $past(hf_cnt[0]))
    else $error("fast counter moved with no request");
// every access gets exactly one answer, on the next edge
ack_next_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    REQ_I.req |=> RSP_O.ack)
    else $error("access not answered next cycle");
ack_idle_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    !REQ_I.req |=> !RSP_O.ack && !RSP_O.err)
    else $error("answer with no access");
// a read outside a write-back slot must leave the stored count alone
rd_nclr_a: assert property (@(posedge CLK_I)
    disable iff (!RESETN_I)
    rd_lower && acc_idx >= 6'(`ESC_FIRST_LF) && state != ESC_WRITE
    |=> mem[$past(acc_idx)] == $past(mem[acc_idx]))
    else $error("read disturbed a counter");
lower_rd_c: cover property (@(posedge CLK_I) rd_lower ##[1:4] rd_upper);
size_pick_c: cover property (@(posedge CLK_I) state == ESC_READ
    && visit != slot);
pend_svc_c: cover property (@(posedge CLK_I) |svc_clr);
bad_up_c: cover property (@(posedge CLK_I) up_err);
wrap_c: cover property (@(posedge CLK_I) state == ESC_WRITE
    && vis_pend && wr_val == '0);

endmodule // esc_stats
